/* include/coproc_port_pkg.sv */
// Purpose: shared constants and types for the coprocessor port
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: handshake codes are the follower's two-bit stage answers
package coproc_port_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BURST_W = 4;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned CLKEN_DIV = 2;
   localparam logic [3:0] BURST_NONE = 4'h0;
   localparam logic [1:0] HS_WAIT = 2'h0;
   localparam logic [1:0] HS_GO = 2'h1;
   localparam logic [1:0] HS_ABSENT = 2'h2;
   localparam logic [1:0] HS_LAST = 2'h3;
   localparam logic [1:0] RES_OK = 2'h0;
   localparam logic [1:0] RES_ABSENT = 2'h1;
   localparam logic [1:0] RES_CANCEL = 2'h2;
   localparam logic [1:0] RES_ABORT = 2'h3;
   // gray coded along idle, decode, execute, memory, transfer, write-back
   typedef enum logic [2:0] {
      IDLE_S = 3'h0,
      DEC_S = 3'h1,
      EXE_S = 3'h3,
      MEM_S = 3'h2,
      XFER_S = 3'h6,
      WB_S = 3'h7
   } port_state_e;
endpackage : coproc_port_pkg

/* core/word_fifo.sv */
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset, depth a power of two
// Notes: full and empty follow the occupancy count exactly
`timescale 1ns/100ps
module word_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clk_i,               // port clock
   input wire logic resetn_i,            // synchronous reset, active low
   input wire logic in_valid_i,          // writer offers a word
   output logic in_ready_o,              // room for a word
   input wire logic [WIDTH-1:0] in_data_i, // word written
   output logic out_valid_o,             // a word is waiting
   input wire logic out_ready_i,         // reader takes the word
   output logic [WIDTH-1:0] out_data_o   // head word
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   // pointer and count update
   always_comb begin
      push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
      pop = out_ready_i && (cnt_reg != '0);
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   // registers only
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
endmodule : word_fifo

/* core/coproc_port.sv */
// Purpose: processor-side port to an external coprocessor pipeline follower
// Assumes: follower runs on clk_i and answers synchronously on it
// Notes: store words pass a small buffer; the follower enable is withheld
//        while a store word is missing, so the buffer stalls the follower
`timescale 1ns/100ps
module coproc_port
   import coproc_port_pkg::*;
#(
   parameter int unsigned DIV = CLKEN_DIV,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input wire logic clk_i,                        // port clock
   input wire logic resetn_i,                     // sync reset, active low
   input wire logic issue_valid_i,                // core offers an instruction
   output logic issue_ready_o,                    // port is idle
   input wire logic [DATA_W-1:0] issue_instr_i,   // instruction word
   input wire logic issue_priv_i,                 // issued in privileged mode
   input wire logic issue_store_i,                // store from core to coprocessor, out
   input wire logic [BURST_W-1:0] issue_burst_i,  // words to move
   input wire logic exec_pass_i,                  // condition passed
   input wire logic late_cancel_i,                // cancel in memory stage
   input wire logic xfer_abort_i,                 // data abort at write-back
   input wire logic wr_valid_i,                   // core store word valid
   output logic wr_ready_o,                       // buffer has room
   input wire logic [DATA_W-1:0] wr_data_i,       // core store word
   output logic rd_valid_o,                       // loaded word pulse
   output logic [DATA_W-1:0] rd_data_o,           // loaded word
   output logic done_o,                           // operation ended pulse
   output logic [1:0] result_o,                   // ok, absent, cancel, abort
   input wire logic coproc_if_enable_i,           // coprocessor present
   input wire logic [1:0] handshake_decode_stage_i,    // decode answer
   input wire logic [1:0] handshake_execute_stage_i,   // execute answer
   input wire logic [DATA_W-1:0] coproc_to_core_data_i, // inbound data
   output logic [DATA_W-1:0] core_to_coproc_data_o,   // outbound data
   output logic [DATA_W-1:0] coproc_instruction_bus_o, // instruction
   output logic instr_valid_n_o,                  // instruction valid, low
   output logic instr_request_n_o,                // take instruction, low
   output logic privileged_access_n_o,            // high when privileged
   output logic follower_clock_enable_o,          // follower advance enable
   output logic coproc_exec_pass_o,               // execute must happen
   output logic coproc_late_cancel_o,             // drop in memory stage
   output logic coproc_xfer_abort_o,              // abort in write-back
   output logic [BURST_W-1:0] coproc_burst_words_o // burst word count
);
   port_state_e state_reg, state_next;
   logic [7:0] div_reg, div_next;
   logic en_reg, en_next;
   logic [DATA_W-1:0] instr_reg, instr_next, out_reg, out_next;
   logic [DATA_W-1:0] rd_reg, rd_next;
   logic vld_n_reg, vld_n_next, req_n_reg, req_n_next;
   logic priv_reg, priv_next, store_reg, store_next, have_reg, have_next;
   logic pass_reg, pass_next, lc_reg, lc_next, ab_reg, ab_next;
   logic rdv_reg, rdv_next, done_reg, done_next, rdy_reg, rdy_next;
   logic [1:0] res_reg, res_next;
   logic [BURST_W-1:0] burst_reg, burst_next, left_reg, left_next;
   logic fifo_valid, fifo_pop;
   logic [DATA_W-1:0] fifo_data;

   // store words wait here until the transfer phase drains them
   word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) store_buf (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .in_data_i(wr_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // sequencer next state and all outputs but wr_ready_o
   always_comb begin
      state_next = state_reg;
      div_next = (div_reg == 8'(DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      instr_next = instr_reg;
      out_next = out_reg;
      rd_next = rd_reg;
      vld_n_next = vld_n_reg;
      req_n_next = req_n_reg;
      priv_next = priv_reg;
      store_next = store_reg;
      have_next = have_reg;
      pass_next = pass_reg;
      lc_next = lc_reg;
      ab_next = ab_reg;
      rdv_next = 1'b0;
      done_next = 1'b0;
      res_next = res_reg;
      burst_next = burst_reg;
      left_next = left_reg;
      fifo_pop = 1'b0;
      case (state_reg)
         IDLE_S: begin
            if (issue_valid_i && rdy_reg && !coproc_if_enable_i) begin
               done_next = 1'b1;
               res_next = RES_ABSENT;
            end else if (issue_valid_i && rdy_reg) begin
               instr_next = issue_instr_i;
               vld_n_next = 1'b0;
               req_n_next = 1'b0;
               priv_next = issue_priv_i;
               store_next = issue_store_i;
               burst_next = issue_burst_i;
               left_next = issue_burst_i;
               state_next = DEC_S;
            end
         end
         DEC_S: begin
            if (en_reg && !req_n_reg) begin
               req_n_next = 1'b1;
            end else if (en_reg) begin
               case (handshake_decode_stage_i)
                  HS_ABSENT: begin
                     res_next = RES_ABSENT;
                     state_next = IDLE_S;
                     done_next = 1'b1;
                  end
                  HS_WAIT: state_next = DEC_S;
                  default: begin
                     pass_next = exec_pass_i;
                     state_next = EXE_S;
                  end
               endcase
            end
         end
         EXE_S: begin
            if (en_reg) begin
               case (handshake_execute_stage_i)
                  HS_WAIT: state_next = EXE_S;
                  HS_ABSENT: begin
                     res_next = RES_ABSENT;
                     state_next = IDLE_S;
                     done_next = 1'b1;
                  end
                  default: begin
                     state_next = pass_reg ? MEM_S : IDLE_S;
                     done_next = !pass_reg;
                     res_next = RES_OK;
                     lc_next = pass_reg && late_cancel_i;
                  end
               endcase
               pass_next = 1'b0;
            end
         end
         MEM_S: begin
            if (en_reg && lc_reg) begin
               res_next = RES_CANCEL;
               state_next = IDLE_S;
               done_next = 1'b1;
            end else if (en_reg) begin
               state_next = (left_reg != BURST_NONE) ? XFER_S : WB_S;
               ab_next = (left_reg == BURST_NONE) && xfer_abort_i;
            end
            if (en_reg) begin
               lc_next = 1'b0;
            end
         end
         XFER_S: begin
            if (en_reg) begin
               left_next = left_reg - 4'h1;
               have_next = 1'b0;
               if (!store_reg) begin
                  rd_next = coproc_to_core_data_i;
                  rdv_next = 1'b1;
               end
               if (left_reg == 4'h1) begin
                  state_next = WB_S;
                  ab_next = xfer_abort_i;
               end
            end else if (store_reg && !have_reg && fifo_valid) begin
               out_next = fifo_data;
               have_next = 1'b1;
               fifo_pop = 1'b1;
            end
         end
         WB_S: begin
            if (en_reg) begin
               res_next = ab_reg ? RES_ABORT : RES_OK;
               ab_next = 1'b0;
               state_next = IDLE_S;
               done_next = 1'b1;
            end
         end
         default: state_next = IDLE_S;
      endcase
      if (state_next == IDLE_S) begin
         vld_n_next = 1'b1;
         req_n_next = 1'b1;
         burst_next = BURST_NONE;
      end
      rdy_next = (state_next == IDLE_S);        // issue refused until set
      // the follower is held while a store word is still missing
      en_next = (div_next == 8'h00) &&
                !(state_next == XFER_S && store_reg && !have_next);
   end

   // registers only; every output but wr_ready_o leaves from one of these
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= IDLE_S;
         div_reg <= 8'h00;
         en_reg <= 1'b0;
         instr_reg <= 32'h0;
         out_reg <= 32'h0;
         rd_reg <= 32'h0;
         vld_n_reg <= 1'b1;
         req_n_reg <= 1'b1;
         priv_reg <= 1'b0;
         store_reg <= 1'b0;
         have_reg <= 1'b0;
         pass_reg <= 1'b0;
         lc_reg <= 1'b0;
         ab_reg <= 1'b0;
         rdv_reg <= 1'b0;
         done_reg <= 1'b0;
         rdy_reg <= 1'b0;
         res_reg <= RES_OK;
         burst_reg <= BURST_NONE;
         left_reg <= BURST_NONE;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         en_reg <= en_next;
         instr_reg <= instr_next;
         out_reg <= out_next;
         rd_reg <= rd_next;
         vld_n_reg <= vld_n_next;
         req_n_reg <= req_n_next;
         priv_reg <= priv_next;
         store_reg <= store_next;
         have_reg <= have_next;
         pass_reg <= pass_next;
         lc_reg <= lc_next;
         ab_reg <= ab_next;
         rdv_reg <= rdv_next;
         done_reg <= done_next;
         rdy_reg <= rdy_next;
         res_reg <= res_next;
         burst_reg <= burst_next;
         left_reg <= left_next;
      end
   end

   // output wiring straight from flip-flops
   assign issue_ready_o = rdy_reg;
   assign rd_valid_o = rdv_reg;
   assign rd_data_o = rd_reg;
   assign done_o = done_reg;
   assign result_o = res_reg;
   assign core_to_coproc_data_o = out_reg;
   assign coproc_instruction_bus_o = instr_reg;
   assign instr_valid_n_o = vld_n_reg;
   assign instr_request_n_o = req_n_reg;
   assign privileged_access_n_o = priv_reg;
   assign follower_clock_enable_o = en_reg;
   assign coproc_exec_pass_o = pass_reg;
   assign coproc_late_cancel_o = lc_reg;
   assign coproc_xfer_abort_o = ab_reg;
   assign coproc_burst_words_o = burst_reg;

   // checks on the port behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   abort_in_wb_a: assert property (ab_reg |-> state_reg == WB_S)
      else $error("abort raised outside write-back");
   burst_idle_a: assert property (
      state_reg == IDLE_S |-> burst_reg == BURST_NONE)
      else $error("burst count not zero while idle");
   advance_on_en_a: assert property (
      state_reg != IDLE_S && !en_reg |=> $stable(state_reg))
      else $error("state moved without follower enable");
   load_capture_a: assert property (
      state_reg == XFER_S && !store_reg && en_reg
      |=> rdv_reg && rd_reg == $past(coproc_to_core_data_i))
      else $error("inbound word not captured");
   instr_hold_a: assert property (
      !req_n_reg && !en_reg |=> $stable(instr_reg) && !req_n_reg)
      else $error("instruction changed before it was taken");
   pass_in_exec_a: assert property (pass_reg |-> state_reg == EXE_S)
      else $error("pass outside execute");
   valid_idle_a: assert property (
      state_reg == IDLE_S |-> vld_n_reg && req_n_reg)
      else $error("instruction marked valid while idle");
   priv_stable_a: assert property (
      state_reg != IDLE_S |=> $stable(priv_reg))
      else $error("privilege changed mid operation");
   word_count_a: assert property (
      state_reg == XFER_S && en_reg
      |=> left_reg == BURST_W'($past(left_reg) - 4'h1))
      else $error("word count did not step");
   store_stall_a: assert property (
      state_reg == XFER_S && store_reg && en_reg |-> have_reg)
      else $error("follower enabled with no store word");

   load_burst_c: cover property (rdv_reg ##1 state_reg == WB_S);
   store_burst_c: cover property (
      state_reg == XFER_S && store_reg && en_reg && left_reg == 4'h2);
   cancel_c: cover property (done_reg && res_reg == RES_CANCEL);
   absent_c: cover property (done_reg && res_reg == RES_ABSENT);
endmodule : coproc_port

/* verif/follower_model.sv */
// Purpose: behavioural coprocessor follower facing the port
// Assumes: follower runs on clk_i and advances only on enabled edges
// Notes: logs taken instructions and store words for the bench to judge
`timescale 1ns/100ps
module follower_model
   import coproc_port_pkg::*;
(
   input wire logic clk_i,                          // port clock
   input wire logic resetn_i,                       // sync reset, active low
   input wire logic present_i,                      // coprocessor attached
   input wire logic [1:0] dec_code_i,               // decode code once done
   input wire logic [1:0] ex_code_i,                // execute code
   input wire logic [3:0] wait_i,                   // decode waits to give
   input wire logic follower_clock_enable_i,        // advance enable
   input wire logic instr_request_n_i,              // take instruction, low
   input wire logic [DATA_W-1:0] coproc_instruction_bus_i, // instruction
   input wire logic coproc_late_cancel_i,           // drop in memory stage
   input wire logic [DATA_W-1:0] core_to_coproc_data_i,    // store word
   output logic coproc_if_enable_o,                 // presence
   output logic [1:0] handshake_decode_stage_o,     // decode answer
   output logic [1:0] handshake_execute_stage_o,    // execute answer
   output logic [DATA_W-1:0] coproc_to_core_data_o  // load word
);
   logic [3:0] wait_reg;
   logic [7:0] word_reg;
   logic [DATA_W-1:0] last_reg;
   int cancel_count;
   logic [DATA_W-1:0] instr_log[$];
   logic [DATA_W-1:0] store_log[$];
   // answers: absent when detached, otherwise decode waits then gives its code, execute gives its code at once
   assign coproc_if_enable_o = present_i;
   assign handshake_decode_stage_o = !present_i ? HS_ABSENT :
      (wait_reg != 4'h0) ? HS_WAIT : dec_code_i;
   assign handshake_execute_stage_o =
      present_i ? ex_code_i : HS_ABSENT;
   // load word steps each enabled edge, so a stale or early sample shows
   assign coproc_to_core_data_o = {24'h5A5A5A, word_reg};
   // follower pipeline moves only on enabled rising edges
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         wait_reg <= 4'h0;
         word_reg <= 8'h00;
         last_reg <= '0;
         cancel_count <= 0;
      end else if (follower_clock_enable_i) begin
         word_reg <= word_reg + 8'h01;
         if (!instr_request_n_i) begin
            instr_log.push_back(coproc_instruction_bus_i);
            wait_reg <= wait_i;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
         end
         // cancelled instruction is only counted; its instr_log entry stays
         if (coproc_late_cancel_i) begin
            cancel_count <= cancel_count + 1;
         end
         if (core_to_coproc_data_i != last_reg) begin
            store_log.push_back(core_to_coproc_data_i);
            last_reg <= core_to_coproc_data_i;
         end
      end
   end
endmodule : follower_model

/* verif/testbench.sv */
// Purpose: self-checking bench for the coprocessor port
// Assumes: inputs driven 10 ns after each rising edge, outputs read there
// Notes: enable divider kept at 2, buffer depth 4
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   err_count++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end
module testbench;
   import coproc_port_pkg::*;
   logic clk_i = 0, resetn_i = 0, issue_valid_i = 0, issue_priv_i = 0;
   logic issue_store_i = 0, exec_pass_i = 1, late_cancel_i = 0;
   logic xfer_abort_i = 0, wr_valid_i = 0, present = 1;
   logic [DATA_W-1:0] issue_instr_i = '0, wr_data_i = '0;
   logic [3:0] issue_burst_i = 4'h0, wait_cnt = 4'h0;
   logic [1:0] dec_code = HS_GO, ex_code = HS_GO, res, hs_de, hs_ex;
   logic issue_ready_o, wr_ready_o, rd_valid_o, done_o, if_en;
   logic [1:0] result_o;
   logic [DATA_W-1:0] rd_data_o, cdin, cdout, instr_bus;
   logic valid_n, req_n, priv_n, clken, pass_o, cancel_o, abort_o;
   logic [3:0] burst_o;
   logic [DATA_W-1:0] rd_q[$];
   logic saw_pass, saw_abort, saw_cancel, en_pair;
   int err_count = 0, tests_run = 0;
   coproc_port #(.DIV(2), .DEPTH(4)) i_coproc_port (.clk_i(clk_i),
      .resetn_i(resetn_i), .issue_valid_i(issue_valid_i),
      .issue_ready_o(issue_ready_o), .issue_instr_i(issue_instr_i),
      .issue_priv_i(issue_priv_i), .issue_store_i(issue_store_i),
      .issue_burst_i(issue_burst_i), .exec_pass_i(exec_pass_i),
      .late_cancel_i(late_cancel_i), .xfer_abort_i(xfer_abort_i),
      .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
      .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .done_o(done_o), .result_o(result_o),
      .coproc_if_enable_i(if_en), .handshake_decode_stage_i(hs_de),
      .handshake_execute_stage_i(hs_ex), .coproc_to_core_data_i(cdin),
      .core_to_coproc_data_o(cdout), .coproc_instruction_bus_o(instr_bus),
      .instr_valid_n_o(valid_n), .instr_request_n_o(req_n),
      .privileged_access_n_o(priv_n), .follower_clock_enable_o(clken),
      .coproc_exec_pass_o(pass_o), .coproc_late_cancel_o(cancel_o),
      .coproc_xfer_abort_o(abort_o), .coproc_burst_words_o(burst_o));
   follower_model i_follower_model (.clk_i(clk_i), .resetn_i(resetn_i),
      .present_i(present), .dec_code_i(dec_code), .ex_code_i(ex_code),
      .wait_i(wait_cnt), .follower_clock_enable_i(clken),
      .instr_request_n_i(req_n), .coproc_instruction_bus_i(instr_bus),
      .coproc_late_cancel_i(cancel_o), .core_to_coproc_data_i(cdout),
      .coproc_if_enable_o(if_en), .handshake_decode_stage_o(hs_de),
      .handshake_execute_stage_o(hs_ex), .coproc_to_core_data_o(cdin));
   // clock of 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // counts, verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   // issue one operation, watch the ports until done or the bound runs out
   task automatic run_op(input logic [31:0] ins, input logic priv,
                         input logic st, input logic [3:0] bst);
      int n;
      logic prev_en;
      rd_q.delete();
      {saw_pass, saw_abort, saw_cancel, en_pair, prev_en} = 5'h00;
      {issue_instr_i, issue_priv_i, issue_store_i} = {ins, priv, st};
      issue_burst_i = bst;
      issue_valid_i = 1'b1;
      for (n = 0; n < 50 && issue_ready_o !== 1'b1; n++) begin
         @(posedge clk_i);
         #10;
      end
      if (n >= 50) begin
         err_count++;
         wrap_up();
      end
      @(posedge clk_i);
      #10;
      issue_valid_i = 1'b0;
      if (present) begin
         `CHECK("ready busy", 1'b0, issue_ready_o)
         `CHECK("instr bus", ins, instr_bus)
         `CHECK("valid_n", 1'b0, valid_n)
         `CHECK("request_n", 1'b0, req_n)
         `CHECK("privilege", priv, priv_n)
         `CHECK("burst", bst, burst_o)
      end
      for (n = 0; n < 300 && done_o !== 1'b1; n++) begin
         if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
         saw_pass |= (pass_o === 1'b1);
         saw_abort |= (abort_o === 1'b1);
         saw_cancel |= (cancel_o === 1'b1);
         en_pair |= (prev_en && clken === 1'b1);
         prev_en = (clken === 1'b1);
         @(posedge clk_i);
         #10;
      end
      res = result_o;
      `CHECK("ready again", 1'b1, issue_ready_o)
      if (n >= 300) begin
         err_count++;
         wrap_up();
      end
   endtask : run_op
   // values held while reset is low
   task automatic t_reset();
      repeat (3) @(posedge clk_i);
      #10;
      `CHECK("reset valid_n", 1'b1, valid_n)
      `CHECK("reset request_n", 1'b1, req_n)
      `CHECK("reset enable", 1'b0, clken)
      `CHECK("reset ready", 1'b0, issue_ready_o)
      `CHECK("reset burst", BURST_NONE, burst_o)
      resetn_i = 1'b1;
      $display("test reset done");
   endtask : t_reset
   // detached coprocessor, then execute stage absent
   task automatic t_absent();
      present = 1'b0;
      run_op(32'hEE000A10, 1'b0, 1'b0, 4'h2);
      `CHECK("detached result", RES_ABSENT, res)
      `CHECK("idle burst", BURST_NONE, burst_o)
      present = 1'b1;
      ex_code = HS_ABSENT;
      run_op(32'hEE000A11, 1'b0, 1'b0, 4'h1);
      `CHECK("exec absent result", RES_ABSENT, res)
      ex_code = HS_GO;
      $display("test absent done");
   endtask : t_absent
   // privileged load of three words with decode stalling twice
   task automatic t_load();
      int i;
      {dec_code, wait_cnt} = {HS_LAST, 4'h2};
      run_op(32'hED901203, 1'b1, 1'b0, 4'h3);
      `CHECK("taken", 32'hED901203, i_follower_model.instr_log[$])
      `CHECK("load words", 3, rd_q.size())
      for (i = 1; i < rd_q.size(); i++) begin
         `CHECK("load step", rd_q[i-1][7:0] + 8'h01, rd_q[i][7:0])
      end
      `CHECK("pass seen", 1'b1, saw_pass)
      `CHECK("enable spacing", 1'b0, en_pair)
      `CHECK("no abort", 1'b0, saw_abort)
      `CHECK("load result", RES_OK, res)
      {dec_code, wait_cnt} = {HS_GO, 4'h0};
      $display("test load done");
   endtask : t_load
   // fill the buffer with four words, check it is refused, then store it all out
   task automatic t_store();
      int i;
      logic [DATA_W-1:0] w;
      i_follower_model.store_log.delete();
      for (i = 0; i < 4; i++) begin
         wr_data_i = 32'hC0FFEE10 + i;
         wr_valid_i = 1'b1;
         @(posedge clk_i);
         #10;
      end
      wr_valid_i = 1'b0;
      `CHECK("buffer full", 1'b0, wr_ready_o)
      run_op(32'hED801204, 1'b0, 1'b1, 4'h4);
      `CHECK("store words", 4, i_follower_model.store_log.size())
      for (i = 0; i < i_follower_model.store_log.size(); i++) begin
         w = i_follower_model.store_log[i];
         `CHECK("store word", 32'hC0FFEE10 + i, w)
      end
      `CHECK("buffer drained", 1'b1, wr_ready_o)
      `CHECK("store result", RES_OK, res)
      $display("test store done");
   endtask : t_store
   // late cancel, abort in write-back, and a failed condition
   task automatic t_endings();
      int c;
      c = i_follower_model.cancel_count;
      late_cancel_i = 1'b1;
      run_op(32'hED901202, 1'b0, 1'b0, 4'h2);
      late_cancel_i = 1'b0;
      `CHECK("cancel result", RES_CANCEL, res)
      `CHECK("cancel seen", 1'b1, saw_cancel)
      `CHECK("dropped", 1'b1, i_follower_model.cancel_count > c)
      `CHECK("cancel words", 0, rd_q.size())
      xfer_abort_i = 1'b1;
      run_op(32'hED901201, 1'b0, 1'b0, 4'h1);
      xfer_abort_i = 1'b0;
      `CHECK("abort seen", 1'b1, saw_abort)
      `CHECK("abort result", RES_ABORT, res)
      exec_pass_i = 1'b0;
      run_op(32'hED901205, 1'b0, 1'b0, 4'h2);
      exec_pass_i = 1'b1;
      `CHECK("no pass", 1'b0, saw_pass)
      `CHECK("no pass words", 0, rd_q.size())
      `CHECK("no pass result", RES_OK, res)
      $display("test endings done");
   endtask : t_endings
   // main sequence
   initial begin
      t_reset();
      t_absent();
      t_load();
      t_store();
      t_endings();
      wrap_up();
   end
endmodule : testbench
